// *** hdl/ctr16_pkg.sv ***
// Constants and types for the 16-bit counter core with byte access.
// Assumes a single system clock and a CPU byte bus on that clock.
package ctr16_pkg;

	// Byte locations on the CPU bus
	localparam int ADDR_W = 3;
	localparam logic [2:0] ADDR_CTRL_A = 3'h0;
	localparam logic [2:0] ADDR_CTRL_B = 3'h1;
	localparam logic [2:0] ADDR_COUNT_LO = 3'h2;
	localparam logic [2:0] ADDR_COUNT_HI = 3'h3;
	localparam logic [2:0] ADDR_FLAGS = 3'h4;

	// Field positions
	localparam int CTRL_A_WGM_LSB = 0;
	localparam int CTRL_B_CS_LSB = 0;
	localparam int CTRL_B_WGM_LSB = 3;
	localparam int FLAGS_OVF_BIT = 0;

	// Reset values
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [7:0] HOLD_RESET = 8'h00;
	localparam logic [2:0] CS_RESET = 3'h0;
	localparam logic [1:0] WGM_PART_RESET = 2'h0;
	localparam logic [7:0] RDATA_RESET = 8'h00;

	// Counter landmarks and fixed tops
	localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
	localparam logic [15:0] COUNT_MAX = 16'hFFFF;
	localparam logic [15:0] TOP_8BIT = 16'h00FF;
	localparam logic [15:0] TOP_9BIT = 16'h01FF;
	localparam logic [15:0] TOP_10BIT = 16'h03FF;
	localparam logic [15:0] COUNT_STEP = 16'h0001;

	// Prescaler width and tap masks
	localparam int PRESC_W = 10;
	localparam logic [9:0] PRESC_RESET = 10'h000;
	localparam logic [9:0] PRESC_MASK_8 = 10'h007;
	localparam logic [9:0] PRESC_MASK_64 = 10'h03F;
	localparam logic [9:0] PRESC_MASK_256 = 10'h0FF;
	localparam logic [9:0] PRESC_MASK_1024 = 10'h3FF;

	// Tick source selection
	typedef enum logic [2:0] {
		CS_STOP = 3'b000,
		CS_DIV1 = 3'b001,
		CS_DIV8 = 3'b010,
		CS_DIV64 = 3'b011,
		CS_DIV256 = 3'b100,
		CS_DIV1024 = 3'b101,
		CS_EXT_FALL = 3'b110,
		CS_EXT_RISE = 3'b111
	} ctr16_clksel_t;

	// Counting sequence families
	typedef enum logic [1:0] {
		SEQ_NORMAL = 2'b00,
		SEQ_CTC = 2'b01,
		SEQ_FAST = 2'b10,
		SEQ_DUAL = 2'b11
	} ctr16_seq_t;

	// Count direction state
	typedef enum logic {
		DIR_UP = 1'b0,
		DIR_DOWN = 1'b1
	} ctr16_dir_t;

endpackage

// *** hdl/ctr16_tick_if.sv ***
// Tick path between the source selector and the counter core.
// Assumes both ends run on the same system clock.
interface ctr16_tick_if;
	import ctr16_pkg::*;
	ctr16_clksel_t clockSel;
	logic tick;
	modport source (input clockSel, output tick);
	modport sink (output clockSel, input tick);
endinterface

// *** hdl/ctr16_tick_sel.sv ***
// Tick source selector: prescaler taps and synchronised external pin edges.
// Assumes the external pin is asynchronous to sys_clk.
module ctr16_tick_sel (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Raw external count pin
	input wire logic extClockPin,
	// Tick path to the core
	ctr16_tick_if.source tickBus
);
	import ctr16_pkg::*;

	logic pinMeta_q;
	logic pinSync_q;
	logic pinLast_q;
	logic [PRESC_W-1:0] presc_q;
	logic [PRESC_W-1:0] presc_d;
	logic pinRise;
	logic pinFall;
	logic tickSel;

	// Two-stage synchroniser, then a third stage for edge detection
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pinMeta_q <= 1'b0;
			pinSync_q <= 1'b0;
			pinLast_q <= 1'b0;
		end else begin
			pinMeta_q <= extClockPin;
			pinSync_q <= pinMeta_q;
			pinLast_q <= pinSync_q;
		end
	end

	// Free-running prescaler
	assign presc_d = presc_q + PRESC_W'(1);
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			presc_q <= PRESC_RESET;
		end else begin
			presc_q <= presc_d;
		end
	end

	assign pinRise = pinSync_q & ~pinLast_q;
	assign pinFall = ~pinSync_q & pinLast_q;

	// Source selection; stop gives no tick at all
	always_comb begin
		case (tickBus.clockSel)
			CS_STOP: tickSel = 1'b0;
			CS_DIV1: tickSel = 1'b1;
			CS_DIV8: tickSel = &(presc_q | ~PRESC_MASK_8);
			CS_DIV64: tickSel = &(presc_q | ~PRESC_MASK_64);
			CS_DIV256: tickSel = &(presc_q | ~PRESC_MASK_256);
			CS_DIV1024: tickSel = &(presc_q | ~PRESC_MASK_1024);
			CS_EXT_FALL: tickSel = pinFall;
			CS_EXT_RISE: tickSel = pinRise;
			default: tickSel = 1'b0;
		endcase
	end

	assign tickBus.tick = tickSel;

endmodule

// *** hdl/ctr16_core.sv ***
// 16-bit up/down counter core reached over an 8-bit CPU bus, with shared holding register.
// Assumes a byte bus on sys_clk with one-cycle read and write strobes, and outside units
// that supply compare and capture tops and share the holding register.
module ctr16_core (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// CPU byte bus
	input wire logic [ctr16_pkg::ADDR_W-1:0] busAddr,
	input wire logic busRead,
	input wire logic busWrite,
	input wire logic [7:0] busWrData,
	output logic [7:0] busRdData,
	// External count pin
	input wire logic extClockPin,
	// Sibling wide registers
	input wire logic siblingLoadHigh,
	input wire logic [7:0] siblingHighByte,
	output logic [7:0] holdHighByte,
	input wire logic [15:0] compareTopValue,
	input wire logic [15:0] captureTopValue,
	// Overflow request
	input wire logic overflowAck,
	output logic overflowFlag,
	// Counter status
	output logic [15:0] countValue,
	output logic countAtTop,
	output logic countAtBottom,
	output logic countDown,
	output logic [3:0] waveformMode,
	output logic timerTick
);
	import ctr16_pkg::*;

	ctr16_tick_if tickBus ();

	logic [15:0] count_q;
	logic [15:0] count_d;
	logic [7:0] hold_q;
	logic [7:0] hold_d;
	logic [2:0] clockSel_q;
	logic [1:0] wgmLo_q;
	logic [1:0] wgmHi_q;
	logic ovf_q;
	logic ovf_d;
	ctr16_dir_t dir_q;
	ctr16_dir_t dir_d;
	logic [7:0] rdData_q;
	logic [7:0] rdMux;
	logic [3:0] wgm;
	ctr16_seq_t seqKind;
	logic [15:0] topValue;
	logic tick;
	logic wrCtrlA;
	logic wrCtrlB;
	logic wrLow;
	logic wrHigh;
	logic wrFlags;
	logic rdLow;
	logic atTop;
	logic atBottom;
	logic atMax;
	logic clearNow;
	logic stepDown;
	logic ovfSet;
	logic ovfClear;

	// Tick source selector
	ctr16_tick_sel tickSelInst (
		.sys_clk(sys_clk),
		.reset(reset),
		.extClockPin(extClockPin),
		.tickBus(tickBus)
	);
	assign tickBus.clockSel = ctr16_clksel_t'(clockSel_q);
	assign tick = tickBus.tick;

	// Bus decode
	assign wrCtrlA = busWrite && (busAddr == ADDR_CTRL_A);
	assign wrCtrlB = busWrite && (busAddr == ADDR_CTRL_B);
	assign wrLow = busWrite && (busAddr == ADDR_COUNT_LO);
	assign wrHigh = busWrite && (busAddr == ADDR_COUNT_HI);
	assign wrFlags = busWrite && (busAddr == ADDR_FLAGS);
	assign rdLow = busRead && (busAddr == ADDR_COUNT_LO);

	// Mode field gathered from both control registers
	assign wgm = {wgmHi_q, wgmLo_q};

	// Mode table: sequence family and top of the count
	always_comb begin
		case (wgm)
			4'h0: begin
				seqKind = SEQ_NORMAL;
				topValue = COUNT_MAX;
			end
			4'h1: begin
				seqKind = SEQ_DUAL;
				topValue = TOP_8BIT;
			end
			4'h2: begin
				seqKind = SEQ_DUAL;
				topValue = TOP_9BIT;
			end
			4'h3: begin
				seqKind = SEQ_DUAL;
				topValue = TOP_10BIT;
			end
			4'h4: begin
				seqKind = SEQ_CTC;
				topValue = compareTopValue;
			end
			4'h5: begin
				seqKind = SEQ_FAST;
				topValue = TOP_8BIT;
			end
			4'h6: begin
				seqKind = SEQ_FAST;
				topValue = TOP_9BIT;
			end
			4'h7: begin
				seqKind = SEQ_FAST;
				topValue = TOP_10BIT;
			end
			4'h8, 4'hA: begin
				seqKind = SEQ_DUAL;
				topValue = captureTopValue;
			end
			4'h9, 4'hB: begin
				seqKind = SEQ_DUAL;
				topValue = compareTopValue;
			end
			4'hC: begin
				seqKind = SEQ_CTC;
				topValue = captureTopValue;
			end
			4'hE: begin
				seqKind = SEQ_FAST;
				topValue = captureTopValue;
			end
			4'hF: begin
				seqKind = SEQ_FAST;
				topValue = compareTopValue;
			end
			default: begin
				seqKind = SEQ_NORMAL;
				topValue = COUNT_MAX;
			end
		endcase
	end

	// Landmark compares
	assign atTop = (count_q == topValue);
	assign atBottom = (count_q == COUNT_BOTTOM);
	assign atMax = (count_q == COUNT_MAX);

	// Single-slope sequences with a top restart from zero
	assign clearNow = atTop && ((seqKind == SEQ_CTC) || (seqKind == SEQ_FAST));

	// Dual slope turns down at top and back up at bottom
	assign stepDown = (seqKind == SEQ_DUAL) &&
		(((dir_q == DIR_UP) && atTop) || ((dir_q == DIR_DOWN) && !atBottom));

	// Counter next value; a CPU low-byte write wins over any tick action
	always_comb begin
		if (wrLow) begin
			count_d = {hold_q, busWrData};
		end else if (!tick) begin
			count_d = count_q;
		end else if (clearNow) begin
			count_d = COUNT_BOTTOM;
		end else if (stepDown) begin
			count_d = count_q - COUNT_STEP;
		end else begin
			count_d = count_q + COUNT_STEP;
		end
	end

	// Direction follows the dual-slope turning points
	always_comb begin
		if (seqKind != SEQ_DUAL) begin
			dir_d = DIR_UP;
		end else if (tick && !wrLow) begin
			dir_d = stepDown ? DIR_DOWN : DIR_UP;
		end else begin
			dir_d = dir_q;
		end
	end

	// Holding register: CPU high-byte write, low-byte read capture, sibling capture
	always_comb begin
		if (wrHigh) begin
			hold_d = busWrData;
		end else if (rdLow) begin
			hold_d = count_q[15:8];
		end else if (siblingLoadHigh) begin
			hold_d = siblingHighByte;
		end else begin
			hold_d = hold_q;
		end
	end

	// Overflow point per sequence family; set beats clear
	assign ovfSet = tick && !wrLow && (
		(((seqKind == SEQ_NORMAL) || (seqKind == SEQ_CTC)) && atMax) ||
		((seqKind == SEQ_FAST) && atTop) ||
		((seqKind == SEQ_DUAL) && atBottom && (dir_q == DIR_DOWN)));
	assign ovfClear = (wrFlags && busWrData[FLAGS_OVF_BIT]) || overflowAck;
	assign ovf_d = ovfSet || (ovf_q && !ovfClear);

	// Read data selection
	always_comb begin
		case (busAddr)
			ADDR_CTRL_A: rdMux = {6'h00, wgmLo_q};
			ADDR_CTRL_B: rdMux = {3'h0, wgmHi_q, clockSel_q};
			ADDR_COUNT_LO: rdMux = count_q[7:0];
			ADDR_COUNT_HI: rdMux = hold_q;
			ADDR_FLAGS: rdMux = {7'h00, ovf_q};
			default: rdMux = 8'h00;
		endcase
	end

	// Counter, holding register and direction
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			count_q <= COUNT_RESET;
			hold_q <= HOLD_RESET;
			dir_q <= DIR_UP;
		end else begin
			count_q <= count_d;
			hold_q <= hold_d;
			dir_q <= dir_d;
		end
	end

	// Control fields
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			clockSel_q <= CS_RESET;
			wgmLo_q <= WGM_PART_RESET;
			wgmHi_q <= WGM_PART_RESET;
		end else begin
			if (wrCtrlA) begin
				wgmLo_q <= busWrData[CTRL_A_WGM_LSB +: 2];
			end
			if (wrCtrlB) begin
				clockSel_q <= busWrData[CTRL_B_CS_LSB +: 3];
				wgmHi_q <= busWrData[CTRL_B_WGM_LSB +: 2];
			end
		end
	end

	// Overflow flag and registered read data
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			ovf_q <= 1'b0;
			rdData_q <= RDATA_RESET;
		end else begin
			ovf_q <= ovf_d;
			if (busRead) begin
				rdData_q <= rdMux;
			end
		end
	end

	// Outputs
	assign busRdData = rdData_q;
	assign holdHighByte = hold_q;
	assign overflowFlag = ovf_q;
	assign countValue = count_q;
	assign countAtTop = atTop;
	assign countAtBottom = atBottom;
	assign countDown = (dir_q == DIR_DOWN);
	assign waveformMode = wgm;
	assign timerTick = tick;

	// Checks on the byte access path
	chk_low_write_load: assert property (@(posedge sys_clk) disable iff (reset)
		wrLow |=> countValue == {$past(holdHighByte), $past(busWrData)})
		else $error("low-byte write did not load both bytes");

	chk_low_read_capture: assert property (@(posedge sys_clk) disable iff (reset)
		rdLow |=> (holdHighByte == $past(countValue[15:8])) && (busRdData == $past(countValue[7:0])))
		else $error("low-byte read did not capture the counter");

	chk_high_read_hold: assert property (@(posedge sys_clk) disable iff (reset)
		(busRead && busAddr == ADDR_COUNT_HI) |=> busRdData == $past(holdHighByte))
		else $error("high-byte read did not return the holding register");

	chk_hold_keep_value: assert property (@(posedge sys_clk) disable iff (reset)
		(wrLow && !siblingLoadHigh && !busRead) |=> $stable(holdHighByte))
		else $error("holding register changed across low-byte writes");

	chk_sibling_shared: assert property (@(posedge sys_clk) disable iff (reset)
		(siblingLoadHigh && !busWrite && !busRead) |=> holdHighByte == $past(siblingHighByte))
		else $error("sibling access did not reach the holding register");

	// Checks on counting
	chk_stop_holds: assert property (@(posedge sys_clk) disable iff (reset)
		(clockSel_q == CS_STOP && !wrLow)[*2] |=> $stable(countValue))
		else $error("counter moved with no tick source");

	chk_normal_step: assert property (@(posedge sys_clk) disable iff (reset)
		(tick && !wrLow && seqKind == SEQ_NORMAL) |=> countValue == 16'($past(countValue) + COUNT_STEP))
		else $error("normal sequence did not advance by one");

	chk_wrap_overflow: assert property (@(posedge sys_clk) disable iff (reset)
		(tick && !wrLow && seqKind == SEQ_NORMAL && atMax) |=> overflowFlag && countAtBottom)
		else $error("wrap past the maximum did not set overflow");

	chk_top_restart: assert property (@(posedge sys_clk) disable iff (reset)
		(tick && !wrLow && seqKind == SEQ_CTC && countAtTop) |=> countValue == COUNT_BOTTOM)
		else $error("top of a clear-on-top sequence did not restart");

	chk_dual_turn: assert property (@(posedge sys_clk) disable iff (reset)
		(tick && !wrLow && seqKind == SEQ_DUAL && countAtTop && !countAtBottom) |=>
		countDown ##0 countValue == 16'($past(countValue) - COUNT_STEP))
		else $error("dual slope did not turn down at top");

	chk_flag_sticky: assert property (@(posedge sys_clk) disable iff (reset)
		(overflowFlag && !overflowAck && !wrFlags) |=> overflowFlag)
		else $error("overflow flag dropped without a clear");

	chk_reset_clear: assert property (@(posedge sys_clk)
		reset |=> (countValue == COUNT_RESET) && (holdHighByte == HOLD_RESET) && !overflowFlag && !timerTick)
		else $error("reset left state behind");

	// Main scenarios
	cov_word_write: cover property (@(posedge sys_clk) disable iff (reset)
		(busWrite && busAddr == ADDR_COUNT_HI) ##1 wrLow);
	cov_word_read: cover property (@(posedge sys_clk) disable iff (reset)
		rdLow ##1 (busRead && busAddr == ADDR_COUNT_HI));
	cov_write_beats_tick: cover property (@(posedge sys_clk) disable iff (reset) wrLow && tick);
	cov_overflow_set: cover property (@(posedge sys_clk) disable iff (reset) ovfSet && ovfClear);

endmodule

// *** testbench/ctr16_cpu_model.sv ***
// CPU side of the byte bus: strobed single-byte accesses and ordered word accesses.
// Assumes the counter core takes a strobe at a rising sys_clk edge and answers a cycle later.
module ctr16_cpu_model (
	// Clock
	input wire logic sys_clk,
	// Byte bus towards the counter core
	output logic [ctr16_pkg::ADDR_W-1:0] busAddr,
	output logic busRead,
	output logic busWrite,
	output logic [7:0] busWrData,
	input wire logic [7:0] busRdData
);
	timeunit 1ns;
	timeprecision 1ps;
	import ctr16_pkg::*;

	// Bus idle at time zero
	initial begin
		busAddr = 3'h7;
		busRead = 1'b0;
		busWrite = 1'b0;
		busWrData = 8'h00;
	end

	// One strobe for one cycle; released lines show inverted values, never the last ones
	task automatic access(input logic wr, input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		busAddr <= a;
		busWrData <= d;
		busWrite <= wr;
		busRead <= !wr;
		@(posedge sys_clk);
		busWrite <= 1'b0;
		busRead <= 1'b0;
		busAddr <= ~a;
		busWrData <= ~d;
		#1;
	endtask

	// Single byte write
	task automatic write_byte(input logic [2:0] a, input logic [7:0] d);
		access(1'b1, a, d);
	endtask

	// Single byte read, data taken once the answer has settled
	task automatic read_byte(input logic [2:0] a, output logic [7:0] q);
		access(1'b0, a, 8'h00);
		q = busRdData;
	endtask

	// Word write, upper byte first; one idle cycle separates the two byte accesses
	task automatic write_word(input logic [15:0] v);
		write_byte(ADDR_COUNT_HI, v[15:8]);
		write_byte(ADDR_COUNT_LO, v[7:0]);
	endtask

	// Word read, lower byte first
	task automatic read_word(output logic [15:0] v);
		read_byte(ADDR_COUNT_LO, v[7:0]);
		read_byte(ADDR_COUNT_HI, v[15:8]);
	endtask
endmodule

// *** testbench/counter16_byte_access_core_tb.sv ***
// Self-checking bench for the counter core, driven through the CPU bus model.
// Assumes a 25 MHz sys_clk and a synchronous active-high reset.
module counter16_byte_access_core_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ctr16_pkg::*;

	logic sys_clk, reset, extClockPin, siblingLoadHigh, overflowAck;
	logic busRead, busWrite, overflowFlag, countAtTop, countAtBottom, countDown, timerTick;
	logic [2:0] busAddr;
	logic [7:0] busWrData, busRdData, holdHighByte, b;
	logic [7:0] siblingHighByte;
	logic [15:0] countValue, w, compareTop, captureTop;
	logic [3:0] waveformMode;
	int failures = 0, samples_checked = 0;

	// Clock
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	ctr16_core i_dut (.sys_clk(sys_clk), .reset(reset), .busAddr(busAddr), .busRead(busRead),
		.busWrite(busWrite), .busWrData(busWrData), .busRdData(busRdData), .extClockPin(extClockPin),
		.siblingLoadHigh(siblingLoadHigh), .siblingHighByte(siblingHighByte), .holdHighByte(holdHighByte),
		.compareTopValue(compareTop), .captureTopValue(captureTop), .overflowAck(overflowAck),
		.overflowFlag(overflowFlag), .countValue(countValue), .countAtTop(countAtTop),
		.countAtBottom(countAtBottom), .countDown(countDown), .waveformMode(waveformMode), .timerTick(timerTick));

	ctr16_cpu_model i_cpu (.sys_clk(sys_clk), .busAddr(busAddr), .busRead(busRead), .busWrite(busWrite),
		.busWrData(busWrData), .busRdData(busRdData));

	// Compare tasks
	task automatic check_val(input logic [15:0] got, input logic [15:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic check_bit(input logic got, input logic exp, input string what);
		check_val({15'h0000, got}, {15'h0000, exp}, what);
	endtask

	// Bounded wait for a count value
	task automatic wait_count(input logic [15:0] exp);
		for (int n = 0; n < 40 && countValue !== exp; n++) begin
			@(posedge sys_clk);
			#1;
		end
		check_val(countValue, exp, "count reached");
	endtask

	task automatic test_reset();
		check_val(countValue, 16'h0000, "count after reset");
		check_bit(countAtBottom, 1'b1, "bottom at zero");
		check_bit(overflowFlag, 1'b0, "flag after reset");
		check_val({8'h00, holdHighByte}, 16'h0000, "holding after reset");
		i_cpu.read_byte(ADDR_CTRL_B, b);
		check_val({8'h00, b}, 16'h0000, "select after reset");
		$display("test reset done");
	endtask

	task automatic test_word_access();
		i_cpu.write_word(16'h01FF);
		check_val(countValue, 16'h01FF, "word write");
		repeat (4) @(posedge sys_clk);
		#1;
		check_val(countValue, 16'h01FF, "stopped count");
		i_cpu.read_word(w);
		check_val(w, 16'h01FF, "word read");
		i_cpu.write_byte(ADDR_COUNT_HI, 8'hAB);
		check_val({8'h00, holdHighByte}, 16'h00AB, "high write to holding");
		check_val(countValue, 16'h01FF, "high write leaves count");
		i_cpu.write_byte(ADDR_COUNT_LO, 8'h12);
		check_val(countValue, 16'hAB12, "first low write");
		i_cpu.write_byte(ADDR_COUNT_LO, 8'h34);
		check_val(countValue, 16'hAB34, "holding reused");
		@(posedge sys_clk);
		siblingLoadHigh <= 1'b1;
		siblingHighByte <= 8'h5A;
		@(posedge sys_clk);
		siblingLoadHigh <= 1'b0;
		i_cpu.read_byte(ADDR_COUNT_HI, b);
		check_val({8'h00, b}, 16'h005A, "sibling shares holding");
		i_cpu.read_byte(3'h5, b);
		check_val({8'h00, b}, 16'h0000, "unmapped read");
		$display("test word access done");
	endtask

	task automatic test_overflow();
		i_cpu.write_word(16'hFFFD);
		i_cpu.write_byte(ADDR_CTRL_B, 8'h01);
		check_bit(timerTick, 1'b1, "tick every cycle");
		wait_count(16'h0000);
		check_bit(countAtBottom, 1'b1, "bottom after wrap");
		@(posedge sys_clk);
		#1;
		check_bit(overflowFlag, 1'b1, "overflow set");
		i_cpu.write_word(16'h0010);
		check_val(countValue, 16'h0010, "write beats count");
		@(posedge sys_clk);
		#1;
		check_val(countValue, 16'h0011, "count resumes");
		i_cpu.read_byte(ADDR_FLAGS, b);
		check_val({8'h00, b}, 16'h0001, "flag readable");
		i_cpu.write_byte(ADDR_FLAGS, 8'h01);
		check_bit(overflowFlag, 1'b0, "flag cleared by write");
		i_cpu.write_word(16'hFFFE);
		wait_count(16'h0000);
		check_bit(overflowFlag, 1'b1, "overflow set again");
		@(posedge sys_clk);
		overflowAck <= 1'b1;
		@(posedge sys_clk);
		overflowAck <= 1'b0;
		#1;
		check_bit(overflowFlag, 1'b0, "flag cleared by ack");
		i_cpu.write_byte(ADDR_CTRL_B, 8'h00);
		check_bit(timerTick, 1'b0, "no tick when stopped");
		w = countValue;
		repeat (3) @(posedge sys_clk);
		#1;
		check_val(countValue, w, "select zero holds");
		$display("test overflow done");
	endtask

	task automatic test_clear_on_top();
		// Counter is stopped before each rewrite, as software must
		@(posedge sys_clk);
		compareTop <= 16'h0005;
		captureTop <= 16'h0003;
		i_cpu.write_word(16'h0000);
		i_cpu.write_byte(ADDR_CTRL_B, 8'h09);
		wait_count(16'h0005);
		check_bit(countAtTop, 1'b1, "compare top reached");
		@(posedge sys_clk);
		#1;
		check_val(countValue, 16'h0000, "restart at compare top");
		i_cpu.write_byte(ADDR_CTRL_B, 8'h18);
		i_cpu.write_word(16'h0000);
		i_cpu.write_byte(ADDR_CTRL_B, 8'h19);
		wait_count(16'h0003);
		check_bit(countAtTop, 1'b1, "capture top reached");
		@(posedge sys_clk);
		#1;
		check_val(countValue, 16'h0000, "restart at capture top");
		i_cpu.write_byte(ADDR_CTRL_B, 8'h00);
		$display("test clear on top done");
	endtask

	task automatic test_dual_slope();
		i_cpu.write_byte(ADDR_CTRL_A, 8'h01);
		check_val({12'h000, waveformMode}, 16'h0001, "mode low bits");
		i_cpu.write_word(16'h00FD);
		i_cpu.write_byte(ADDR_CTRL_B, 8'h01);
		wait_count(16'h00FF);
		check_bit(countAtTop, 1'b1, "top indication");
		@(posedge sys_clk);
		#1;
		check_val(countValue, 16'h00FE, "turns down at top");
		check_bit(countDown, 1'b1, "direction down");
		i_cpu.write_byte(ADDR_CTRL_B, 8'h18);
		check_val({12'h000, waveformMode}, 16'h000D, "mode split field");
		i_cpu.write_byte(ADDR_CTRL_A, 8'h00);
		i_cpu.write_byte(ADDR_CTRL_B, 8'h00);
		$display("test dual slope done");
	endtask

	task automatic test_sources();
		i_cpu.write_word(16'h0000);
		i_cpu.write_byte(ADDR_CTRL_B, 8'h02);
		repeat (80) @(posedge sys_clk);
		i_cpu.write_byte(ADDR_CTRL_B, 8'h00);
		check_bit(countValue >= 16'd9 && countValue <= 16'd11, 1'b1, "divide by eight");
		// External pin: falling then rising edge select, three pulses each
		for (int k = 0; k < 2; k++) begin
			i_cpu.write_word(16'h0000);
			i_cpu.write_byte(ADDR_CTRL_B, 8'h06 + 8'(k));
			repeat (3) begin
				@(posedge sys_clk);
				extClockPin <= 1'b1;
				repeat (4) @(posedge sys_clk);
				extClockPin <= 1'b0;
				repeat (4) @(posedge sys_clk);
			end
			repeat (4) @(posedge sys_clk);
			i_cpu.write_byte(ADDR_CTRL_B, 8'h00);
			check_val(countValue, 16'h0003, "external edges counted");
		end
		$display("test sources done");
	endtask

	// Verdict
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		reset = 1'b1;
		extClockPin = 1'b0;
		siblingLoadHigh = 1'b0;
		overflowAck = 1'b0;
		siblingHighByte = 8'h00;
		compareTop = 16'h0000;
		captureTop = 16'h0000;
		repeat (5) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		#1;
		test_reset();
		test_word_access();
		test_overflow();
		test_dual_slope();
		test_clear_on_top();
		test_sources();
		end_of_test();
	end

	// Watchdog
	initial begin
		repeat (5000) @(posedge sys_clk);
		failures++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		end_of_test();
	end
endmodule
